//--- logic/pwrseq_pkg.sv
// pwrseq_pkg: constants and carrier types of the handset power sequencer
// assumes one 20 MHz housekeeping clock shared by every user of these names
package pwrseq_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 20_000_000;
  localparam int DEBOUNCE_MS     = 20;   // key must stay steady this long
  localparam int HOLD_TIMEOUT_MS = 500;  // wait for keep-alive after release
  localparam int CNT_W           = 24;
  localparam int STEP_W          = 16;
  localparam logic [CNT_W-1:0] DEBOUNCE_CYCLES =
    CNT_W'((CLK_HZ / 1000) * DEBOUNCE_MS);
  localparam logic [CNT_W-1:0] HOLD_TIMEOUT_CYCLES =
    CNT_W'((CLK_HZ / 1000) * HOLD_TIMEOUT_MS);

  // ----------------------------------------------------------------
  // regulator indices and order
  // ----------------------------------------------------------------
  localparam int N_DEF = 4;                     // default-on regulators
  localparam logic [1:0] IDX_PERIPH  = 2'h0;
  localparam logic [1:0] IDX_CORE    = 2'h1;
  localparam logic [1:0] IDX_ANALOG  = 2'h2;
  localparam logic [1:0] IDX_REF_OSC = 2'h3;
  // power-up order, slot 0 first; power-down walks it backwards
  localparam logic [7:0] DEF_ON_ORDER = {IDX_REF_OSC, IDX_ANALOG, IDX_CORE, IDX_PERIPH};
  localparam logic [1:0] LAST_SLOT    = 2'h3;
  localparam logic [N_DEF-1:0] DEF_ALL_ON = 4'hF;
  localparam logic [N_DEF-1:0] DEF_ALL_OFF = 4'h0;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic periph_supply;
    logic core_supply;
    logic analog_supply;
    logic ref_osc_supply;
    logic receiver_supply;
    logic transmitter_supply;
    logic camera_supply;
  } supply_en_t;

  typedef struct packed {
    logic receiver_supply;
    logic transmitter_supply;
    logic camera_supply;
  } opt_req_t;

endpackage

//--- logic/key_debounce.sv
// key_debounce: two-flop synchroniser plus steady-level filter for a pin
// assumes an active-low reset already synchronised to clk; idle level is high
`timescale 1ns/1ps
`default_nettype none
module key_debounce #(
  parameter logic [pwrseq_pkg::CNT_W-1:0] STABLE_CYCLES = pwrseq_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_sync_n,
  input  wire logic raw_n,
  output logic      level_n
);

  // ----------------------------------------------------------------
  // synchroniser and filter
  // ----------------------------------------------------------------
  logic                         meta;
  logic                         sync;
  logic [pwrseq_pkg::CNT_W-1:0] count;
  wire                          differs = (sync != level_n);
  wire                          settled = (count >= STABLE_CYCLES - 1'b1);

  // meta is read only by sync
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      meta <= 1'b1;
      sync <= 1'b1;
    end else begin
      meta <= raw_n;
      sync <= meta;
    end
  end

  // any bounce restarts the count, so a glitch never reaches level_n
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      count   <= '0;
      level_n <= 1'b1;
    end else if (!differs) begin
      count <= '0;
    end else if (settled) begin
      count   <= '0;
      level_n <= sync;
    end else begin
      count <= count + 1'b1;
    end
  end

endmodule // key_debounce
`default_nettype wire

//--- logic/handset_power_sequencer.sv
// handset_power_sequencer: power-on and power-off sequencing of the supplies
// assumes a free-running ref_clk; key and keep-alive arrive asynchronously
`timescale 1ns/1ps
`default_nettype none
module handset_power_sequencer #(
  parameter logic [7:0]                   ON_ORDER       = pwrseq_pkg::DEF_ON_ORDER,
  parameter logic [pwrseq_pkg::CNT_W-1:0] DEBOUNCE_CYCLES = pwrseq_pkg::DEBOUNCE_CYCLES,
  parameter logic [pwrseq_pkg::CNT_W-1:0] HOLD_CYCLES    = pwrseq_pkg::HOLD_TIMEOUT_CYCLES
) (
  input  wire logic                          ref_clk,
  input  wire logic                          rst_n,
  input  wire logic                          power_key_sense_n,
  input  wire logic                          supply_keep_alive,
  input  wire logic [pwrseq_pkg::STEP_W-1:0] step_cycles,
  input  wire pwrseq_pkg::opt_req_t          opt_request,
  output logic                               poweron_reset_out_n,
  output pwrseq_pkg::supply_en_t             supplies
);

  // ----------------------------------------------------------------
  // reset release and input synchronisers
  // ----------------------------------------------------------------
  logic rst_meta_n;
  logic rst_sync_n;
  logic ka_meta;
  logic ka_sync;
  logic key_level_n;
  logic key_prev_n;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // keep-alive comes from the other chip; ka_meta feeds ka_sync only
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ka_meta    <= 1'b0;
      ka_sync    <= 1'b0;
      key_prev_n <= 1'b1;
    end else begin
      ka_meta    <= supply_keep_alive;
      ka_sync    <= ka_meta;
      key_prev_n <= key_level_n;
    end
  end

  key_debounce #(
    .STABLE_CYCLES (DEBOUNCE_CYCLES)
  ) u_key (
    .clk        (ref_clk),
    .rst_sync_n (rst_sync_n),
    .raw_n      (power_key_sense_n),
    .level_n    (key_level_n)
  );

  // a press is the debounced falling edge, so a key still held after
  // power-off does not restart the handset at once
  wire key_press = key_prev_n & ~key_level_n;

  // ----------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OFF, ST_ON_STEP, ST_RELEASE, ST_WAIT_HOLD, ST_RUN, ST_ASSERT_RST, ST_OFF_STEP
  } seq_state_t;

  seq_state_t                              state;
  seq_state_t                              next_state;
  logic [pwrseq_pkg::STEP_W-1:0]           timer;
  logic [pwrseq_pkg::STEP_W-1:0]           next_timer;
  logic [1:0]                              slot;
  logic [1:0]                              next_slot;
  logic [pwrseq_pkg::N_DEF-1:0]            def_en;
  logic [pwrseq_pkg::N_DEF-1:0]            next_def_en;
  logic [pwrseq_pkg::CNT_W-1:0]            hold_cnt;
  logic [pwrseq_pkg::CNT_W-1:0]            next_hold_cnt;
  logic                                    next_reset_n;
  logic [2:0]                              opt_en;
  logic [2:0]                              next_opt_en;

  // slot decode into regulator index, forward for on and backward for off
  wire [1:0] on_idx   = ON_ORDER[{slot, 1'b0} +: 2];
  wire [1:0] off_idx  = ON_ORDER[{pwrseq_pkg::LAST_SLOT - slot, 1'b0} +: 2];
  wire [pwrseq_pkg::N_DEF-1:0] on_mask  = pwrseq_pkg::N_DEF'(1) << on_idx;
  wire [pwrseq_pkg::N_DEF-1:0] off_mask = pwrseq_pkg::N_DEF'(1) << off_idx;
  wire tick       = (timer == '0);
  wire last_slot  = (slot == pwrseq_pkg::LAST_SLOT);
  wire hold_late  = (hold_cnt >= HOLD_CYCLES - 1'b1);

  // next-state logic; the step timer reloads on every step taken
  always_comb begin
    next_state    = state;
    next_timer    = tick ? timer : timer - 1'b1;
    next_slot     = slot;
    next_def_en   = def_en;
    next_hold_cnt = '0;
    unique case (state)
      ST_OFF: begin
        if (key_press) begin
          next_state = ST_ON_STEP;
          next_timer = step_cycles;
          next_slot  = 2'h0;
        end
      end
      ST_ON_STEP: begin
        if (tick) begin
          next_def_en = def_en | on_mask;
          next_timer  = step_cycles;
          next_slot   = slot + 1'b1;
          if (last_slot) begin
            next_state = ST_RELEASE;
          end
        end
      end
      ST_RELEASE: begin
        if (tick) begin
          next_state = ST_WAIT_HOLD;
        end
      end
      ST_WAIT_HOLD: begin
        next_hold_cnt = hold_cnt + 1'b1;
        if (ka_sync) begin
          next_state = ST_RUN;
        end else if (hold_late) begin
          next_state = ST_ASSERT_RST;
        end
      end
      ST_RUN: begin
        if (!ka_sync) begin
          next_state = ST_ASSERT_RST;
        end
      end
      ST_ASSERT_RST: begin
        next_state = ST_OFF_STEP;
        next_timer = step_cycles;
        next_slot  = 2'h0;
      end
      ST_OFF_STEP: begin
        if (tick) begin
          next_def_en = def_en & ~off_mask;
          next_timer  = step_cycles;
          next_slot   = slot + 1'b1;
          if (last_slot) begin
            next_state = ST_OFF;
          end
        end
      end
    endcase
  end

  // reset out is high only while the processor may run
  assign next_reset_n = (next_state == ST_WAIT_HOLD) || (next_state == ST_RUN);
  // optional supplies follow their requests only while running
  assign next_opt_en  = (next_state == ST_RUN) ? opt_request : 3'h0;

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state               <= ST_OFF;
      timer               <= '0;
      slot                <= 2'h0;
      def_en              <= pwrseq_pkg::DEF_ALL_OFF;
      hold_cnt            <= '0;
      poweron_reset_out_n <= 1'b0;
      opt_en              <= 3'h0;
    end else begin
      state               <= next_state;
      timer               <= next_timer;
      slot                <= next_slot;
      def_en              <= next_def_en;
      hold_cnt            <= next_hold_cnt;
      poweron_reset_out_n <= next_reset_n;
      opt_en              <= next_opt_en;
    end
  end

  // ----------------------------------------------------------------
  // output mapping
  // ----------------------------------------------------------------
  assign supplies.periph_supply      = def_en[pwrseq_pkg::IDX_PERIPH];
  assign supplies.core_supply        = def_en[pwrseq_pkg::IDX_CORE];
  assign supplies.analog_supply      = def_en[pwrseq_pkg::IDX_ANALOG];
  assign supplies.ref_osc_supply     = def_en[pwrseq_pkg::IDX_REF_OSC];
  assign supplies.receiver_supply    = opt_en[2];
  assign supplies.transmitter_supply = opt_en[1];
  assign supplies.camera_supply      = opt_en[0];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_sync_n);

  property p_on_reset_low;
    (state == ST_ON_STEP) |-> !poweron_reset_out_n;
  endproperty
  a_on_reset_low: assert property (p_on_reset_low)
    else $error("reset out high during power-up steps");

  property p_one_at_a_time;
    $countones(def_en ^ $past(def_en)) <= 1;
  endproperty
  a_one_at_a_time: assert property (p_one_at_a_time)
    else $error("more than one supply switched in a cycle");

  property p_release_after_up;
    $rose(poweron_reset_out_n) |-> (def_en == pwrseq_pkg::DEF_ALL_ON);
  endproperty
  a_release_after_up: assert property (p_release_after_up)
    else $error("reset released before default supplies up");

  property p_hold_low_resets;
    (state == ST_RUN && !ka_sync) |=> !poweron_reset_out_n ##1 (state == ST_OFF_STEP);
  endproperty
  a_hold_low_resets: assert property (p_hold_low_resets)
    else $error("keep-alive low did not assert reset");

  property p_off_after_reset;
    (|($past(def_en) & ~def_en)) |-> !poweron_reset_out_n && (state != ST_RUN);
  endproperty
  a_off_after_reset: assert property (p_off_after_reset)
    else $error("supply dropped while reset released");

  property p_optional_gated;
    (opt_en != 3'h0) |-> (state == ST_RUN) && (def_en == pwrseq_pkg::DEF_ALL_ON);
  endproperty
  a_optional_gated: assert property (p_optional_gated)
    else $error("optional supply on outside run");

  property p_press_needed;
    (state == ST_OFF && !key_press) |=> (state == ST_OFF) && (def_en == 4'h0);
  endproperty
  a_press_needed: assert property (p_press_needed)
    else $error("power-up started without debounced press");

  property p_step_spacing;
    (def_en != $past(def_en)) |-> ($past(timer) == 16'h0);
  endproperty
  a_step_spacing: assert property (p_step_spacing)
    else $error("supply stepped before delay elapsed");

  property p_hold_timeout;
    (state == ST_WAIT_HOLD && !ka_sync && hold_late) |=> !poweron_reset_out_n;
  endproperty
  a_hold_timeout: assert property (p_hold_timeout)
    else $error("late keep-alive did not power down");

  c_power_up: cover property ($rose(poweron_reset_out_n));
  c_run: cover property (state == ST_WAIT_HOLD ##1 state == ST_RUN);
  c_power_down: cover property (state == ST_OFF_STEP ##1 state == ST_OFF);
  c_timeout: cover property (state == ST_WAIT_HOLD && hold_late && !ka_sync);

endmodule // handset_power_sequencer
`default_nettype wire

//--- bench/bb_proc_model.sv
// bb_proc_model: processor side of the keep-alive handshake
// assumes reset_in_n comes straight from the sequencer, same clock
`timescale 1ns/1ps
`default_nettype none
module bb_proc_model #(
  parameter int HOLD_DELAY = 3,
  parameter int KEY_LIMIT  = 20
) (
  input  wire logic clk,
  input  wire logic reset_in_n,
  input  wire logic key_n,
  input  wire logic silent,
  output logic      keep_alive
);
  // ----------------------------------------------------------------
  // keep-alive and key timing
  // ----------------------------------------------------------------
  int unsigned up_cnt;
  int unsigned key_cnt;

  // pins held low in reset; silent models a processor that never boots
  always_ff @(posedge clk or negedge reset_in_n) begin
    if (!reset_in_n) begin
      up_cnt     <= 0;
      key_cnt    <= 0;
      keep_alive <= 1'b0;
    end else begin
      if (up_cnt < HOLD_DELAY) begin
        up_cnt <= up_cnt + 1;
      end else if (!silent && key_cnt < KEY_LIMIT) begin
        keep_alive <= 1'b1;
      end
      key_cnt <= key_n ? 0 : ((key_cnt < KEY_LIMIT) ? key_cnt + 1 : key_cnt);
      if (key_cnt >= KEY_LIMIT) begin
        keep_alive <= 1'b0;
      end
    end
  end
endmodule  // bb_proc_model
`default_nettype wire

//--- bench/handset_power_sequencer_tb_top.sv
// handset_power_sequencer_tb_top: self-checking bench of the sequencer
// assumes the design package, design and processor model compile first
`timescale 1ns/1ps
`default_nettype none
module handset_power_sequencer_tb_top;
  localparam int HOLD = 50;
  typedef struct packed {logic [2:0] req; logic [6:0] exp;} row_t;
  logic                          ref_clk = 1'b0;
  logic                          rst_n = 1'b0;
  logic                          key_n = 1'b1;
  logic                          silent = 1'b0;
  logic [pwrseq_pkg::STEP_W-1:0] step = 16'h0003;
  pwrseq_pkg::opt_req_t          opt = 3'h0;
  logic                          por_n;
  pwrseq_pkg::supply_en_t        sup;
  logic                          keep;
  int                            n_mismatch = 0;
  int                            check_count = 0;
  int                            n;
  logic [6:0]                    up_seq [4] = '{7'h40, 7'h60, 7'h70, 7'h78};
  row_t                          rows [5] = '{'{3'h0, 7'h78}, '{3'h4, 7'h7C},
                                              '{3'h2, 7'h7A}, '{3'h1, 7'h79}, '{3'h7, 7'h7F}};

  // ----------------------------------------------------------------
  // clock, design and processor
  // ----------------------------------------------------------------
  always #25 ref_clk = ~ref_clk;

  handset_power_sequencer #(.DEBOUNCE_CYCLES(24'h000004), .HOLD_CYCLES(24'h000032)) DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .power_key_sense_n(key_n),
    .supply_keep_alive(keep), .step_cycles(step), .opt_request(opt),
    .poweron_reset_out_n(por_n), .supplies(sup));

  bb_proc_model model (.clk(ref_clk), .reset_in_n(por_n), .key_n(key_n),
    .silent(silent), .keep_alive(keep));

  // ----------------------------------------------------------------
  // helper tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // sample just after the edge so the design's updates have landed
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask

  task automatic timeout();
    n_mismatch++;
    $display("ERROR %0t: wait ran out", $time);
    tally_and_finish();
  endtask

  // wait for the next supply change, then check value, reset and spacing
  task automatic step_to(input logic [6:0] exp, input logic rexp, input int gap);
    logic [6:0] last;
    last = sup;
    n = 0;
    do begin tick(); n++; end while (sup === last && n < 300);
    if (n >= 300) timeout();
    check(sup, exp);
    check(por_n, rexp);
    if (gap > 0) check(n, gap);
  endtask

  task automatic wait_rst(input logic lvl);
    n = 0;
    do begin tick(); n++; end while (por_n !== lvl && n < 400);
    if (n >= 400) timeout();
  endtask

  task automatic power_up();
    @(posedge ref_clk) key_n <= 1'b0;
    for (int i = 0; i < 4; i++) step_to(up_seq[i], 1'b0, i ? step + 1 : 0);
    wait_rst(1'b1);
    check(n, step + 1);
    check(sup, 7'h78);
    @(posedge ref_clk) key_n <= 1'b1;
  endtask

  // reverse order; first step waits one extra cycle behind the reset
  task automatic power_down();
    for (int i = 3; i >= 0; i--) step_to(i ? up_seq[i-1] : 7'h00, 1'b0, step + (i == 3 ? 2 : 1));
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge ref_clk);
    check(sup, 7'h00);
    check(por_n, 1'b0);
    rst_n <= 1'b1;
    // short key glitch must not start anything
    repeat (4) @(posedge ref_clk);
    key_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    key_n <= 1'b1;
    repeat (30) tick();
    check(sup, 7'h00);
    power_up();
    repeat (10) tick();
    // optional supplies follow requests only while running
    for (int i = 0; i < 5; i++) begin
      @(posedge ref_clk) opt <= rows[i].req;
      repeat (2) tick();
      check(sup, rows[i].exp);
    end
    // keep-alive answered in time, so reset stays released past the hold limit
    repeat (HOLD) tick();
    check(por_n, 1'b1);
    // long key hold makes the processor drop keep-alive
    @(posedge ref_clk) key_n <= 1'b0;
    wait_rst(1'b0);
    check(sup, 7'h78);
    power_down();
    repeat (30) tick();
    check(sup, 7'h00);
    @(posedge ref_clk) key_n <= 1'b1;
    opt <= 3'h0;
    // processor never raises keep-alive; fastest step setting
    silent <= 1'b1;
    step <= 16'h0000;
    repeat (10) @(posedge ref_clk);
    power_up();
    wait_rst(1'b0);
    check((n >= HOLD - 2) && (n <= HOLD + 4), 1'b1);
    power_down();
    // reset in mid power-up clears everything at once
    @(posedge ref_clk) silent <= 1'b0;
    repeat (10) @(posedge ref_clk);
    key_n <= 1'b0;
    step_to(7'h40, 1'b0, 0);
    @(posedge ref_clk) rst_n <= 1'b0;
    #1;
    check(sup, 7'h00);
    check(por_n, 1'b0);
    tally_and_finish();
  end
endmodule  // handset_power_sequencer_tb_top
`default_nettype wire
